// ### src/ebpsd_pkg.sv
// Shared types and constants for the external bus pin state decoder.
// Assumes one 100 MHz clock and an active-low asynchronous reset.
package ebpsd_pkg;

  // ----------------------------------------------------------------
  // Sizes and bit positions
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 30;
  localparam int DATA_W   = 32;
  localparam int LANES    = 4;
  localparam int LANE_W   = 8;
  localparam int AREAS    = 9;
  localparam int CARDS    = 4;
  localparam int BANK_BIT = 25;

  // ----------------------------------------------------------------
  // Access descriptors
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AREA_SYNC_ROM = 3'h0,
    AREA_SDRAM    = 3'h1,
    AREA_MUX_IO   = 3'h2,
    AREA_BURST_IO = 3'h3,
    AREA_CARD_MEM = 3'h4
  } ebpsd_kind_type;

  typedef enum logic [1:0] {
    WIDTH_8  = 2'h0,
    WIDTH_16 = 2'h1,
    WIDTH_32 = 2'h2
  } ebpsd_width_type;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } ebpsd_size_type;

  typedef struct packed {
    logic              valid;
    ebpsd_kind_type    kind;
    logic [3:0]        area;
    ebpsd_width_type   width;
    logic              write;
    ebpsd_size_type    size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              addr_phase;
  } ebpsd_req_type;

  typedef struct packed {
    logic [AREAS-1:0] area_chip_select_n;
    logic [CARDS-1:0] card_enable_n;
    logic             bus_cycle_start_n;
    logic             row_strobe_upper_n;
    logic             row_strobe_lower_n;
    logic             column_strobe_upper_n;
    logic             column_strobe_lower_n;
    logic             byte_mask_lane3;
    logic             byte_mask_lane2;
    logic             byte_mask_lane1;
    logic             byte_mask_lane0;
    logic             address_hold;
    logic             frame_n;
    logic             transfer_direction;
    logic             read_strobe_n;
    logic             card_io_read_strobe_n;
    logic             card_io_write_strobe_n;
    logic [LANES-1:0] write_strobe_n;
    logic             mem_write_enable_n;
  } ebpsd_pins_type;

  // Idle bus: every strobe inactive, address hold low
  localparam ebpsd_pins_type PINS_IDLE = '{address_hold: 1'b0,
                                           default: '1};
  localparam logic [ADDR_W-1:0] ADDR_RESET = '0;
  localparam logic [DATA_W-1:0] DATA_RESET = '0;

endpackage

// ### src/ebpsd_lane_decode.sv
// Byte lane selection for one access, big-endian lane order.
// Assumes aligned accesses; misaligned low bits are ignored per size.
`timescale 1ns/10ps
module ebpsd_lane_decode (
  input  wire ebpsd_pkg::ebpsd_width_type width,   // Area bus width
  input  wire ebpsd_pkg::ebpsd_size_type  size,    // Access size
  input  wire logic [1:0]                 addr_lo, // Address bits 1:0
  output logic [ebpsd_pkg::LANES-1:0]     lanes    // Lanes carrying data
);

  always_comb begin
    lanes = 4'h0;
    unique case (width)
      ebpsd_pkg::WIDTH_8: begin
        lanes = 4'h1;
      end
      ebpsd_pkg::WIDTH_16: begin
        if (size == ebpsd_pkg::SIZE_BYTE) begin
          lanes = addr_lo[0] ? 4'h1 : 4'h2; // RULE4
        end else begin
          lanes = 4'h3; // RULE4
        end
      end
      ebpsd_pkg::WIDTH_32: begin
        unique case (size)
          ebpsd_pkg::SIZE_BYTE: lanes = 4'h8 >> addr_lo; // RULE3
          ebpsd_pkg::SIZE_WORD: lanes = addr_lo[1] ? 4'h3 : 4'hc; // RULE3
          default:              lanes = 4'hf; // RULE3
        endcase
      end
      default: begin
        lanes = 4'h0;
      end
    endcase
  end

endmodule

// ### src/ebpsd_decoder.sv
// Pin state decoder for external bus accesses of one area.
// Assumes the on-chip master holds req stable for the whole access and
// the pad ring resolves the data pins from data_oe_q.
`timescale 1ns/10ps

// Operation
// RULE1: Only the addressed area's chip select low
// RULE2: Full address on A29..A0 whole access
// RULE3: 32-bit area big-endian lanes, rest Hi-Z
// RULE4: 16-bit area uses low lanes, upper Hi-Z
// RULE5: Burst ROM reads only, write strobes high
// RULE6: SDRAM strobes pick bank by A25
// RULE7: 16-bit SDRAM masks low lanes, upper masked
// RULE8: 32-bit SDRAM masks per lane, direction by access
// RULE9: Multiplexed I/O: hold high, low strobes
// RULE10: Multiplexed lanes share address and data
// RULE11: Burst multiplexed: frame low, hold low
// RULE12: Burst multiplexed writes strobe each lane
// RULE13: Card memory: card enable, chip selects high
// RULE14: Only accessed card enable driven low
// RULE15: Lanes from size, address, area width
module ebpsd_decoder (
  input  wire logic                        clk,          // 100 MHz clock
  input  wire logic                        nrst,         // Async reset
  input  wire ebpsd_pkg::ebpsd_req_type    req,          // Access request
  input  wire logic [ebpsd_pkg::DATA_W-1:0] data_in,     // Data pins in
  output ebpsd_pkg::ebpsd_pins_type        pins_q,       // Control pins
  output logic [ebpsd_pkg::ADDR_W-1:0]     addr_q,       // A29..A0
  output logic [ebpsd_pkg::DATA_W-1:0]     data_out_q,   // Data pins out
  output logic [ebpsd_pkg::LANES-1:0]      data_oe_q,    // Per-lane enable
  output logic [ebpsd_pkg::DATA_W-1:0]     rdata_q       // Captured read
);

  // ----------------------------------------------------------------
  // Lane selection
  // ----------------------------------------------------------------
  logic [ebpsd_pkg::LANES-1:0] lanes;
  logic [ebpsd_pkg::LANES-1:0] in_width;
  logic [ebpsd_pkg::DATA_W-1:0] addr_wide;

  ebpsd_lane_decode u_lanes (
    .width   (req.width),
    .size    (req.size),
    .addr_lo (req.addr[1:0]),
    .lanes   (lanes)
  ); // RULE15

  assign in_width  = (req.width == ebpsd_pkg::WIDTH_32) ? 4'hf :
                     (req.width == ebpsd_pkg::WIDTH_16) ? 4'h3 : 4'h1;
  assign addr_wide = {2'h0, req.addr};

  // ----------------------------------------------------------------
  // Control pins
  // ----------------------------------------------------------------
  ebpsd_pkg::ebpsd_pins_type    pins_d;
  logic [ebpsd_pkg::ADDR_W-1:0] addr_d;
  logic                         active;
  logic                         mux;

  // A write to burst ROM has no cycle; the request is left idle
  assign active = req.valid && // RULE5
                  !(req.kind == ebpsd_pkg::AREA_SYNC_ROM && req.write);
  assign mux    = (req.kind == ebpsd_pkg::AREA_MUX_IO) ||
                  (req.kind == ebpsd_pkg::AREA_BURST_IO);

  always_comb begin
    pins_d = ebpsd_pkg::PINS_IDLE;
    addr_d = addr_q;
    if (active) begin
      addr_d = req.addr; // RULE2
      pins_d.bus_cycle_start_n  = 1'b0;
      pins_d.transfer_direction = !req.write; // RULE8
      pins_d.read_strobe_n      = req.write;
      if (req.kind == ebpsd_pkg::AREA_CARD_MEM) begin
        pins_d.card_enable_n[req.area[1:0]] = 1'b0; // RULE13 RULE14
      end else begin
        pins_d.area_chip_select_n[req.area] = 1'b0; // RULE1
      end
      unique case (req.kind)
        ebpsd_pkg::AREA_SDRAM: begin
          pins_d.read_strobe_n = 1'b1; // RULE8
          if (req.addr[ebpsd_pkg::BANK_BIT]) begin // RULE6
            pins_d.row_strobe_upper_n    = 1'b0;
            pins_d.column_strobe_upper_n = 1'b0;
          end else begin
            pins_d.row_strobe_lower_n    = 1'b0;
            pins_d.column_strobe_lower_n = 1'b0;
          end
          // Upper masks stay high in a 16-bit area since lanes[3:2]=0
          pins_d.byte_mask_lane3 = !lanes[3]; // RULE7 RULE8
          pins_d.byte_mask_lane2 = !lanes[2]; // RULE7 RULE8
          pins_d.byte_mask_lane1 = !lanes[1]; // RULE7 RULE8
          pins_d.byte_mask_lane0 = !lanes[0]; // RULE7 RULE8
        end
        ebpsd_pkg::AREA_MUX_IO: begin
          pins_d.address_hold = 1'b1; // RULE9
          if (req.write) begin
            pins_d.write_strobe_n = ~(lanes & 4'h3); // RULE9
          end
        end
        ebpsd_pkg::AREA_BURST_IO: begin
          pins_d.frame_n = 1'b0; // RULE11
          if (req.write) begin
            pins_d.write_strobe_n = ~lanes; // RULE12
          end
        end
        default: begin
          pins_d.write_strobe_n = '1; // RULE5
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data lanes
  // ----------------------------------------------------------------
  logic [ebpsd_pkg::DATA_W-1:0] data_out_d;
  logic [ebpsd_pkg::LANES-1:0]  data_oe_d;

  for (genvar i = 0; i < ebpsd_pkg::LANES; i++) begin : g_lane
    logic show_addr;
    // Multiplexed lanes within the area width that carry no data show address throughout the access
    assign show_addr = mux && in_width[i] &&
                       (req.addr_phase || !lanes[i]); // RULE10 RULE11
    always_comb begin
      data_oe_d[i] = active && (show_addr ||
                     (req.write && lanes[i] && in_width[i])); // RULE3 RULE4
      data_out_d[i*ebpsd_pkg::LANE_W +: ebpsd_pkg::LANE_W] =
        show_addr ? addr_wide[i*ebpsd_pkg::LANE_W +: ebpsd_pkg::LANE_W]
                  : req.wdata[i*ebpsd_pkg::LANE_W +: ebpsd_pkg::LANE_W];
    end
  end

  // Read data is sampled while the previous cycle was a read
  logic [ebpsd_pkg::DATA_W-1:0] rdata_d;
  assign rdata_d = (!pins_q.bus_cycle_start_n && pins_q.transfer_direction)
                   ? data_in : rdata_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins_q     <= ebpsd_pkg::PINS_IDLE;
      addr_q     <= ebpsd_pkg::ADDR_RESET;
      data_out_q <= ebpsd_pkg::DATA_RESET;
      data_oe_q  <= '0;
      rdata_q    <= ebpsd_pkg::DATA_RESET;
    end else begin
      pins_q     <= pins_d;
      addr_q     <= addr_d;
      data_out_q <= data_out_d;
      data_oe_q  <= data_oe_d;
      rdata_q    <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cs_single_area: assert property ( // RULE1
    @(posedge clk) disable iff (!nrst)
    (!pins_q.bus_cycle_start_n && pins_q.card_enable_n == 4'hf)
    |-> $countones(~pins_q.area_chip_select_n) == 1)
    else $error("chip select not one-hot");

  a_addr_follows: assert property ( // RULE2
    @(posedge clk) disable iff (!nrst)
    active |=> addr_q == $past(req.addr))
    else $error("address not driven");

  a_long_lanes: assert property ( // RULE3
    @(posedge clk) disable iff (!nrst)
    (active && req.kind == ebpsd_pkg::AREA_SDRAM && req.write &&
     req.width == ebpsd_pkg::WIDTH_32 && req.size == ebpsd_pkg::SIZE_LONG)
    |=> data_oe_q == 4'hf)
    else $error("longword lanes wrong");

  a_narrow_upper: assert property ( // RULE4
    @(posedge clk) disable iff (!nrst)
    (req.width == ebpsd_pkg::WIDTH_16) |=> data_oe_q[3:2] == 2'h0)
    else $error("upper lanes driven in 16-bit area");

  a_rom_read_only: assert property ( // RULE5
    @(posedge clk) disable iff (!nrst)
    (req.valid && req.kind == ebpsd_pkg::AREA_SYNC_ROM)
    |=> pins_q.transfer_direction && pins_q.write_strobe_n == 4'hf
        && pins_q.mem_write_enable_n)
    else $error("burst ROM write strobes");

  a_sdram_bank: assert property ( // RULE6
    @(posedge clk) disable iff (!nrst)
    (active && req.kind == ebpsd_pkg::AREA_SDRAM)
    |=> (pins_q.row_strobe_upper_n ==
         !$past(req.addr[ebpsd_pkg::BANK_BIT])) &&
        (pins_q.column_strobe_lower_n ==
         $past(req.addr[ebpsd_pkg::BANK_BIT])))
    else $error("SDRAM bank strobe wrong");

  a_sdram16_mask: assert property ( // RULE7
    @(posedge clk) disable iff (!nrst)
    (active && req.kind == ebpsd_pkg::AREA_SDRAM &&
     req.width == ebpsd_pkg::WIDTH_16)
    |=> pins_q.byte_mask_lane3 && pins_q.byte_mask_lane2 &&
        !(pins_q.byte_mask_lane1 && pins_q.byte_mask_lane0))
    else $error("16-bit SDRAM masks wrong");

  a_sdram_dir: assert property ( // RULE8
    @(posedge clk) disable iff (!nrst)
    (active && req.kind == ebpsd_pkg::AREA_SDRAM)
    |=> pins_q.read_strobe_n &&
        pins_q.transfer_direction == !$past(req.write))
    else $error("SDRAM direction wrong");

  a_burst_frame: assert property ( // RULE11
    @(posedge clk) disable iff (!nrst)
    (active && req.kind == ebpsd_pkg::AREA_BURST_IO)
    |=> !pins_q.frame_n && !pins_q.address_hold)
    else $error("burst frame wrong");

  a_card_no_cs: assert property ( // RULE13
    @(posedge clk) disable iff (!nrst)
    (active && req.kind == ebpsd_pkg::AREA_CARD_MEM)
    |=> pins_q.area_chip_select_n == 9'h1ff &&
        $countones(~pins_q.card_enable_n) == 1)
    else $error("card access chip selects");

endmodule

// ### tb/ebpsd_ext_mem.sv
// Behavioural external memories on the far side of the pin decoder.
// Assumes the decoder's registered pins; per-lane pad resolution here.
`timescale 1ns/10ps
module ebpsd_ext_mem (
  input  wire logic                      clk,        // Bus clock
  input  wire ebpsd_pkg::ebpsd_pins_type pins_q,     // Control pins
  input  wire logic [29:0]               addr_q,     // Address pins
  input  wire logic [31:0]               data_out_q, // Decoder data
  input  wire logic [3:0]                data_oe_q,  // Decoder lane enables
  output logic [31:0]                    data_in     // Resolved data pins
);
  logic [31:0] last_q = 32'h0;
  logic [31:0] mem_drv;
  logic        rd;

  assign rd = !pins_q.bus_cycle_start_n && pins_q.transfer_direction;
  // Released bus must not look like a stale hold of the last read
  assign mem_drv = rd ? ({2'h0, addr_q} ^ 32'h5a5a_a5a5) : ~last_q;

  always @(posedge clk) begin
    if (rd)
      last_q <= mem_drv;
  end

  always_comb begin
    for (int i = 0; i < 4; i++)
      data_in[8*i +: 8] = data_oe_q[i] ? data_out_q[8*i +: 8]
                                       : mem_drv[8*i +: 8];
  end
endmodule

// ### tb/external_bus_pin_state_decoder_bench.sv
// Self-checking bench for the external bus pin state decoder.
// Assumes ebpsd_pkg, the decoder and the external memory model.
`timescale 1ns/10ps
module external_bus_pin_state_decoder_bench;
  logic                      clk;
  logic                      nrst;
  ebpsd_pkg::ebpsd_req_type  req;
  logic [31:0]               data_in;
  ebpsd_pkg::ebpsd_pins_type pins_q;
  logic [29:0]               addr_q;
  logic [31:0]               data_out_q;
  logic [3:0]                data_oe_q;
  logic [31:0]               rdata_q;
  int                        mismatches;
  int                        checked;

`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin \
  mismatches++; $display("MISMATCH %0t %s", $time, m); end end

  ebpsd_decoder u_ebpsd_decoder (.clk(clk), .nrst(nrst), .req(req),
    .data_in(data_in), .pins_q(pins_q), .addr_q(addr_q),
    .data_out_q(data_out_q), .data_oe_q(data_oe_q), .rdata_q(rdata_q));
  ebpsd_ext_mem u_ebpsd_ext_mem (.clk(clk), .pins_q(pins_q),
    .addr_q(addr_q), .data_out_q(data_out_q), .data_oe_q(data_oe_q),
    .data_in(data_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Expectations
  // ------------------------------------------------------------------
  function automatic logic [3:0] wl_of(ebpsd_pkg::ebpsd_width_type w);
    return (w == ebpsd_pkg::WIDTH_32) ? 4'hf :
           (w == ebpsd_pkg::WIDTH_16) ? 4'h3 : 4'h1;
  endfunction

  function automatic logic [3:0] ln_of(ebpsd_pkg::ebpsd_req_type r);
    if (r.width == ebpsd_pkg::WIDTH_8) return 4'h1;
    if (r.width == ebpsd_pkg::WIDTH_16)
      return (r.size != ebpsd_pkg::SIZE_BYTE) ? 4'h3 :
             r.addr[0] ? 4'h1 : 4'h2;
    if (r.size == ebpsd_pkg::SIZE_LONG) return 4'hf;
    if (r.size == ebpsd_pkg::SIZE_WORD) return r.addr[1] ? 4'h3 : 4'hc;
    return 4'h8 >> r.addr[1:0];
  endfunction

  function automatic ebpsd_pkg::ebpsd_pins_type exp_pins(
      ebpsd_pkg::ebpsd_req_type r);
    ebpsd_pkg::ebpsd_pins_type e;
    logic [3:0] ln;
    ln = ln_of(r);
    e = ebpsd_pkg::PINS_IDLE;
    e.bus_cycle_start_n = 1'b0;
    if (r.kind == ebpsd_pkg::AREA_CARD_MEM)
      e.card_enable_n = ~(4'h1 << r.area[1:0]);
    else
      e.area_chip_select_n = ~(9'h1 << r.area);
    e.transfer_direction = !r.write;
    e.read_strobe_n = r.write || r.kind == ebpsd_pkg::AREA_SDRAM;
    case (r.kind)
      ebpsd_pkg::AREA_SDRAM: begin
        if (r.addr[25]) begin
          e.row_strobe_upper_n = 1'b0;
          e.column_strobe_upper_n = 1'b0;
        end else begin
          e.row_strobe_lower_n = 1'b0;
          e.column_strobe_lower_n = 1'b0;
        end
        {e.byte_mask_lane3, e.byte_mask_lane2, e.byte_mask_lane1,
         e.byte_mask_lane0} = ~ln;
      end
      ebpsd_pkg::AREA_MUX_IO: begin
        e.address_hold = 1'b1;
        if (r.write) e.write_strobe_n = ~ln;
      end
      ebpsd_pkg::AREA_BURST_IO: begin
        e.frame_n = 1'b0;
        if (r.write) e.write_strobe_n = ~ln;
      end
      default: ;
    endcase
    return e;
  endfunction

  // ------------------------------------------------------------------
  // Shared access and sweep
  // ------------------------------------------------------------------
  task automatic acc(ebpsd_pkg::ebpsd_req_type r);
    ebpsd_pkg::ebpsd_pins_type e;
    logic [3:0]  ln;
    logic [3:0]  al;
    logic [3:0]  oe;
    logic [31:0] m;
    logic [31:0] am;
    logic [31:0] aw;
    logic [31:0] rx;
    ln = ln_of(r);
    e = exp_pins(r);
    aw = {2'h0, r.addr};
    m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
    al = 4'h0;
    // Multiplexed lanes within the width show address in the address phase, otherwise unless carrying data
    if (r.kind == ebpsd_pkg::AREA_MUX_IO ||
        r.kind == ebpsd_pkg::AREA_BURST_IO)
      al = r.addr_phase ? wl_of(r.width) : wl_of(r.width) & ~ln;
    am = {{8{al[3]}}, {8{al[2]}}, {8{al[1]}}, {8{al[0]}}};
    oe = al | (r.write ? ln : 4'h0);
    // Lanes the decoder drives read back its own value at the pads
    rx = r.addr_phase ? aw : aw ^ 32'h5a5a_a5a5;
    req = r;
    @(negedge clk);
    `CHK(pins_q, e, "pins")
    `CHK(pins_q.area_chip_select_n, e.area_chip_select_n, "cs")
    `CHK(pins_q.card_enable_n, e.card_enable_n, "ce")
    `CHK(pins_q.write_strobe_n, e.write_strobe_n, "wr")
    `CHK(addr_q, r.addr, "address")
    `CHK(data_oe_q, oe, "lane enables")
    `CHK(data_out_q & am, aw & am, "address lanes")
    if (r.write && !r.addr_phase)
      `CHK(data_out_q & m, r.wdata & m, "write data")
    if (!r.write) begin
      @(negedge clk);
      `CHK(rdata_q & m, rx & m, "read")
    end
  endtask

  task automatic sweep(ebpsd_pkg::ebpsd_kind_type k,
                       ebpsd_pkg::ebpsd_width_type w);
    ebpsd_pkg::ebpsd_req_type r;
    int ai;
    for (int wr = 0; wr < 2; wr++)
      for (int ap = 0; ap < 2; ap++)
        for (int sz = 0; sz < 3; sz++)
          for (int off = 0; off < 4; off++) begin
            if (ap == 1 && k != ebpsd_pkg::AREA_MUX_IO &&
                k != ebpsd_pkg::AREA_BURST_IO) continue;
            if (wr == 1 && k == ebpsd_pkg::AREA_SYNC_ROM) continue;
            ai = off + 4 * sz + wr;
            r = '0;
            r.valid = 1'b1;
            r.kind = k;
            r.area = 4'((k == ebpsd_pkg::AREA_CARD_MEM) ? ai : ai % 9);
            r.width = w;
            r.write = wr[0];
            r.size = ebpsd_pkg::ebpsd_size_type'(sz);
            r.addr = 30'h0123_4560 | 30'(off);
            r.addr[25] = off[1] ^ wr[0];
            r.wdata = 32'hc3a5_965a ^ {2'h0, r.addr};
            r.addr_phase = ap[0];
            acc(r);
          end
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_sdram();
    sweep(ebpsd_pkg::AREA_SDRAM, ebpsd_pkg::WIDTH_16);
    sweep(ebpsd_pkg::AREA_SDRAM, ebpsd_pkg::WIDTH_32);
  endtask

  task automatic t_rom();
    logic [29:0]              held;
    ebpsd_pkg::ebpsd_req_type r;
    sweep(ebpsd_pkg::AREA_SYNC_ROM, ebpsd_pkg::WIDTH_16);
    sweep(ebpsd_pkg::AREA_SYNC_ROM, ebpsd_pkg::WIDTH_32);
    held = addr_q;
    r = req;
    r.write = 1'b1;
    r.addr = 30'h0abc_def0;
    req = r;
    @(negedge clk);
    `CHK(pins_q, ebpsd_pkg::PINS_IDLE, "rom write pins")
    `CHK(addr_q, held, "rom write address")
  endtask

  task automatic t_mux();
    sweep(ebpsd_pkg::AREA_MUX_IO, ebpsd_pkg::WIDTH_8);
    sweep(ebpsd_pkg::AREA_MUX_IO, ebpsd_pkg::WIDTH_16);
    sweep(ebpsd_pkg::AREA_BURST_IO, ebpsd_pkg::WIDTH_32);
  endtask

  task automatic t_card();
    sweep(ebpsd_pkg::AREA_CARD_MEM, ebpsd_pkg::WIDTH_8);
    sweep(ebpsd_pkg::AREA_CARD_MEM, ebpsd_pkg::WIDTH_16);
  endtask

  task automatic t_reset();
    // Reset acts without a clock edge, mid-access
    nrst = 1'b0;
    #1;
    `CHK(pins_q, ebpsd_pkg::PINS_IDLE, "reset pins")
    `CHK(data_oe_q, 4'h0, "reset enables")
    `CHK(addr_q, ebpsd_pkg::ADDR_RESET, "reset address")
    `CHK(rdata_q, ebpsd_pkg::DATA_RESET, "reset read data")
    @(negedge clk);
    nrst = 1'b1;
    req.valid = 1'b0;
    // First edge after release must leave the bus idle
    @(negedge clk);
    `CHK(pins_q, ebpsd_pkg::PINS_IDLE, "idle after reset")
    `CHK(data_oe_q, 4'h0, "idle enables")
  endtask

  task automatic complete_run();
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    complete_run();
  end

  initial begin
    mismatches = 0;
    checked = 0;
    nrst = 1'b0;
    req = '0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    t_sdram();
    t_rom();
    t_mux();
    t_card();
    t_reset();
    t_sdram();
    complete_run();
  end
endmodule
